// *** dv/gicm_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module gicm_assertions (input wire logic i_clock, i_reset_n, i_write, i_read, o_irq,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata, o_rdata, i_pin, i_out_data, i_out_enable, o_pin, o_pin_oe);
default clocking @(posedge i_clock); endclocking
default disable iff (!i_reset_n);
sequence s_wr(a, r); i_write && i_addr == a && &i_wdata ##1 i_read && i_addr == r; endsequence
property p_rz; !i_read |=> o_rdata == 0; endproperty
a_rz: assert property (p_rz) else $error("idle rdata");
property p_oe; (o_pin_oe & ~$past(i_out_enable)) == 0; endproperty
a_oe: assert property (p_oe) else $error("drive");
property p_hi; (o_pin & ~$past(i_out_data)) == 0; endproperty
a_hi: assert property (p_hi) else $error("high");
property p_pin; $stable(i_pin)[*3] ##0 i_read && i_addr == 8'h00 |=> o_rdata == $past(i_pin); endproperty
a_pin: assert property (p_pin) else $error("level");
property p_en; s_wr(8'h04, 8'h0C) |=> &o_rdata; endproperty
a_en: assert property (p_en) else $error("enable");
property p_dis; s_wr(8'h18, 8'h1C) |=> o_rdata == 0; endproperty
a_dis: assert property (p_dis) else $error("od off");
property p_clr; $stable(i_pin)[*3] ##0 i_read && i_addr == 8'h10 |=> !o_irq; endproperty
a_clr: assert property (p_clr) else $error("clear");
property p_irq; i_write && i_addr == 8'h08 && &i_wdata |=> !o_irq; endproperty
a_irq: assert property (p_irq) else $error("irq");
endmodule : gicm_assertions
bind gicm_top gicm_assertions gicm_assertions_i (.*);
`default_nettype wire

// *** dv/gicm_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module gicm_pins (input wire logic [31:0] i_drv, i_oe, i_ext, output logic [31:0] o_level);
	// Released lines take the outside party or pull-up level
	assign o_level = (i_oe & i_drv) | (~i_oe & i_ext);
endmodule : gicm_pins
`default_nettype wire

// *** dv/gicm_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module gicm_top_tb;
logic i_clock = 0, i_reset_n = 0, i_write = 0, i_read = 0, o_irq, rv = 0;
logic [7:0] i_addr = 0;
logic [31:0] i_wdata = 0, o_rdata, i_pin, i_out_data = 0, i_out_enable = 0, o_pin, o_pin_oe, ext = 0, v, w;
logic [31:0] q[$];
logic [31:0] od;
logic [15:0] lf = 16'h7C5B;
int err_total = 0, n_compared = 0;
always #2.5 i_clock = ~i_clock;
gicm_top gicm_top_i (.*);
gicm_pins gicm_pins_i (.i_drv(o_pin), .i_oe(o_pin_oe), .i_ext(ext), .o_level(i_pin));
function automatic logic [31:0] rnd();
	for (int k = 0; k < 32; k++) begin
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		rnd = {rnd[30:0], lf[0]};
	end
endfunction : rnd
task automatic chk(input string n, input logic [31:0] s, e);
	n_compared++;
	if (s !== e) begin
		err_total++;
		$display("Error %s exp %h seen %h", n, e, s);
	end
endtask : chk
task automatic wr(input logic [7:0] a, input logic [31:0] d);
	@(posedge i_clock);
	{i_addr, i_wdata, i_write, i_read} <= {a, d, 2'b10};
endtask : wr
task automatic rd(input logic [7:0] a, input logic [31:0] e);
	@(posedge i_clock);
	{i_addr, i_write, i_read} <= {a, 2'b01};
	q.push_back(e);
endtask : rd
task automatic idle();
	@(posedge i_clock);
	{i_write, i_read} <= 2'b00;
endtask : idle
task automatic end_of_test();
	$display("Compared %0d errors %0d", n_compared, err_total);
	if (err_total == 0 && n_compared > 0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
endtask : end_of_test
always @(posedge i_clock) rv <= i_read;
always @(negedge i_clock) if (rv) chk("o_rdata", o_rdata, q.pop_front());
initial begin
	#20000 err_total++;
	end_of_test();
end
initial begin
	repeat (5) @(posedge i_clock);
	i_reset_n <= 1;
	rd(8'h0C, 0);
	rd(8'h10, 0);
	rd(8'h20, 0);
	for (int b = 0; b < 32; b += 16) begin
		v = rnd();
		w = rnd();
		wr(8'(8'h04 + b), '1);
		rd(8'(8'h0C + b), '1);
		wr(8'(8'h08 + b), '1);
		rd(8'(8'h0C + b), 0);
		wr(8'(8'h04 + b), v);
		wr(8'(8'h08 + b), w);
		rd(8'(8'h0C + b), v & ~w);
	end
	od = v & ~w;
	wr(8'h04, '1);
	idle();
	v = rnd();
	ext <= v;
	repeat (3) @(posedge i_clock);
	@(negedge i_clock) chk("o_irq", o_irq, |v);
	rd(8'h00, v);
	rd(8'h10, v);
	rd(8'h10, 0);
	idle();
	@(negedge i_clock) chk("o_irq", o_irq, 0);
	@(posedge i_clock);
	i_out_enable <= rnd();
	i_out_data <= rnd();
	repeat (2) @(posedge i_clock);
	@(negedge i_clock);
	v = i_out_enable & ~(od & i_out_data);
	w = i_out_data & ~od;
	chk("o_pin_oe", o_pin_oe, v);
	chk("o_pin", o_pin, w);
	rd(8'h00, (v & w) | (~v & ext));
	idle();
	@(posedge i_clock);
	i_reset_n <= 0;
	i_out_enable <= 0;
	repeat (2) @(posedge i_clock);
	i_reset_n <= 1;
	rd(8'h0C, 0);
	rd(8'h10, 0);
	rd(8'h1C, 0);
	idle();
	repeat (2) @(posedge i_clock);
	end_of_test();
end
endmodule : gicm_top_tb
`default_nettype wire

// *** hdl/gicm_pkg.sv ***
package gicm_pkg;
	// Register word offsets (byte addresses)
	localparam logic [7:0] PIN_LEVEL_STATUS_OFS = 8'h00;
	localparam logic [7:0] CHANGE_IRQ_ENABLE_OFS = 8'h04;
	localparam logic [7:0] CHANGE_IRQ_DISABLE_OFS = 8'h08;
	localparam logic [7:0] CHANGE_IRQ_MASK_OFS = 8'h0C;
	localparam logic [7:0] CHANGE_IRQ_STATUS_OFS = 8'h10;
	localparam logic [7:0] OPEN_DRAIN_ENABLE_OFS = 8'h14;
	localparam logic [7:0] OPEN_DRAIN_DISABLE_OFS = 8'h18;
	localparam logic [7:0] OPEN_DRAIN_STATUS_OFS = 8'h1C;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] OPEN_DRAIN_RESET = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : gicm_pkg

// *** hdl/gicm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: Each of 32 lines owns its same bit position in every register.
// R02: Pin level register reads current level of each pin, 1 high, 0 low.
// R03: Writing 1 to change-interrupt enable sets that line's enable; 0 no effect.
// R04: Writing 1 to change-interrupt disable clears that line's enable; 0 no effect.
// R05: Mask register reads 1 for enabled lines, 0 for disabled lines.
// R06: Status bit sets once a level change is seen on its line.
// R07: Reading status or reset clears all bits until new change.
// R08: Writing 1 to open-drain enable turns on multi-drive for line.
// R09: Writing 1 to open-drain disable turns off multi-drive for line.
// R10: Open-drain status reads 1 where multi-drive is enabled.
// R11: With multi-drive on, pin is only driven low, released for high.
// R12: With multi-drive off, pin is driven high and low per output data.
// R13: Interrupt output high while any line has status and mask both set.
module gicm_top #(
	parameter int LINES = 32
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [31:0] o_rdata,
	input wire logic [LINES-1:0] i_pin,
	input wire logic [LINES-1:0] i_out_data,
	input wire logic [LINES-1:0] i_out_enable,
	output logic [LINES-1:0] o_pin,
	output logic [LINES-1:0] o_pin_oe,
	output logic o_irq
);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [LINES-1:0] level;
		logic [LINES-1:0] mask;
		logic [LINES-1:0] status;
		logic [LINES-1:0] open_drain;
		logic [LINES-1:0] pin_out;
		logic [LINES-1:0] pin_oe;
		logic [31:0] rdata;
		logic irq;
		logic primed;
	} gicm_state_s;

	gicm_state_s state_q;
	gicm_state_s state_d;

	////////////////////////////////////////////////////////////////////////
	// Register access decode
	logic wr_irq_enable;
	logic wr_irq_disable;
	logic wr_od_enable;
	logic wr_od_disable;
	logic rd_irq_status;
	logic [LINES-1:0] wr_bits;

	assign wr_irq_enable = i_write && (i_addr == gicm_pkg::CHANGE_IRQ_ENABLE_OFS);
	assign wr_irq_disable = i_write && (i_addr == gicm_pkg::CHANGE_IRQ_DISABLE_OFS);
	assign wr_od_enable = i_write && (i_addr == gicm_pkg::OPEN_DRAIN_ENABLE_OFS);
	assign wr_od_disable = i_write && (i_addr == gicm_pkg::OPEN_DRAIN_DISABLE_OFS);
	assign rd_irq_status = i_read && (i_addr == gicm_pkg::CHANGE_IRQ_STATUS_OFS);
	// Bit n of the write word belongs to line n
	assign wr_bits = LINES'(i_wdata); // R01

	////////////////////////////////////////////////////////////////////////
	// Set and clear requests per line; a zero bit in the write word asks for nothing
	logic [LINES-1:0] mask_set;
	logic [LINES-1:0] mask_clr;
	logic [LINES-1:0] od_set;
	logic [LINES-1:0] od_clr;

	assign mask_set = wr_irq_enable ? wr_bits : '0; // R03
	assign mask_clr = wr_irq_disable ? wr_bits : '0; // R04
	assign od_set = wr_od_enable ? wr_bits : '0; // R08
	assign od_clr = wr_od_disable ? wr_bits : '0; // R09

	////////////////////////////////////////////////////////////////////////
	// Per-line next values
	logic [LINES-1:0] change;
	logic [LINES-1:0] mask_next;
	logic [LINES-1:0] od_next;
	logic [LINES-1:0] status_next;
	logic [LINES-1:0] out_next;
	logic [LINES-1:0] oe_next;
	logic [LINES-1:0] pending;

	for (genvar g = 0; g < LINES; g++) begin : g_line
		logic change_bit;
		logic mask_bit;
		logic od_bit;
		logic status_bit;
		logic out_bit;
		logic oe_bit;

		// The first sample after reset has no history, so it never counts as a change
		always_comb begin
			if (state_q.primed) begin
				change_bit = i_pin[g] ^ state_q.level[g]; // R06
			end else begin
				change_bit = 1'b0;
			end
		end

		always_comb begin
			if (mask_set[g]) begin
				mask_bit = 1'b1; // R03
			end else if (mask_clr[g]) begin
				mask_bit = 1'b0; // R04
			end else begin
				mask_bit = state_q.mask[g];
			end
		end

		always_comb begin
			if (od_set[g]) begin
				od_bit = 1'b1; // R08
			end else if (od_clr[g]) begin
				od_bit = 1'b0; // R09
			end else begin
				od_bit = state_q.open_drain[g];
			end
		end

		// A status read clears the bit; a change of that same cycle goes out in the read word
		always_comb begin
			if (rd_irq_status) begin
				status_bit = 1'b0; // R07
			end else if (change_bit) begin
				status_bit = 1'b1; // R06
			end else begin
				status_bit = state_q.status[g];
			end
		end

		// An open-drain line never drives a high
		always_comb begin
			if (od_bit) begin
				out_bit = 1'b0; // R11
			end else begin
				out_bit = i_out_data[g]; // R12
			end
		end

		// An open-drain line with a high to send is released instead
		always_comb begin
			if (od_bit) begin
				oe_bit = i_out_enable[g] & ~i_out_data[g]; // R11
			end else begin
				oe_bit = i_out_enable[g]; // R12
			end
		end

		assign change[g] = change_bit;
		assign mask_next[g] = mask_bit;
		assign od_next[g] = od_bit;
		assign status_next[g] = status_bit;
		assign out_next[g] = out_bit;
		assign oe_next[g] = oe_bit;
		assign pending[g] = status_bit & mask_bit; // R13
	end

	////////////////////////////////////////////////////////////////////////
	// Read word; write-only and unmapped offsets answer with zero
	logic [31:0] read_word;

	always_comb begin
		read_word = gicm_pkg::UNMAPPED_READ;
		if (i_read) begin
			case (i_addr)
				gicm_pkg::PIN_LEVEL_STATUS_OFS: begin
					read_word = 32'(state_q.level); // R02
				end
				gicm_pkg::CHANGE_IRQ_MASK_OFS: begin
					read_word = 32'(state_q.mask); // R05
				end
				gicm_pkg::CHANGE_IRQ_STATUS_OFS: begin
					// Changes of this cycle are reported now, as the read clears them
					read_word = 32'(state_q.status | change); // R07
				end
				gicm_pkg::OPEN_DRAIN_STATUS_OFS: begin
					read_word = 32'(state_q.open_drain); // R10
				end
				gicm_pkg::CHANGE_IRQ_ENABLE_OFS: begin
					read_word = gicm_pkg::UNMAPPED_READ;
				end
				gicm_pkg::CHANGE_IRQ_DISABLE_OFS: begin
					read_word = gicm_pkg::UNMAPPED_READ;
				end
				gicm_pkg::OPEN_DRAIN_ENABLE_OFS: begin
					read_word = gicm_pkg::UNMAPPED_READ;
				end
				gicm_pkg::OPEN_DRAIN_DISABLE_OFS: begin
					read_word = gicm_pkg::UNMAPPED_READ;
				end
				default: begin
					read_word = gicm_pkg::UNMAPPED_READ;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_d = state_q;
		state_d.level = i_pin; // R02
		state_d.primed = 1'b1;
		state_d.mask = mask_next;
		state_d.open_drain = od_next;
		state_d.status = status_next;
		state_d.pin_out = out_next;
		state_d.pin_oe = oe_next;
		state_d.rdata = read_word;
		// Interrupt moves in the same cycle as the status and mask it is made from
		state_d.irq = |pending; // R13
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q.level <= '0;
			state_q.mask <= LINES'(gicm_pkg::MASK_RESET);
			state_q.status <= LINES'(gicm_pkg::STATUS_RESET); // R07
			state_q.open_drain <= LINES'(gicm_pkg::OPEN_DRAIN_RESET);
			state_q.pin_out <= '0;
			state_q.pin_oe <= '0;
			state_q.rdata <= gicm_pkg::UNMAPPED_READ;
			state_q.irq <= 1'b0;
			state_q.primed <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs come straight from the state register
	assign o_rdata = state_q.rdata;
	assign o_pin = state_q.pin_out;
	assign o_pin_oe = state_q.pin_oe;
	assign o_irq = state_q.irq;

endmodule : gicm_top
`default_nettype wire
